// [hw/pfs_defines.svh]
// Register offsets, field positions and reset values of the pin function select block.
`ifndef PFS_DEFINES_SVH
`define PFS_DEFINES_SVH
`define PFS_ADDR_W 32
`define PFS_OFF_SEL_HIGH 32'he002c004
`define PFS_OFF_SEL_P1 32'he002c014
`define PFS_OFF_GPIO_DIR 32'he002c100
`define PFS_OFF_GPIO_OUT 32'he002c104
`define PFS_OFF_GPIO_SET 32'he002c108
`define PFS_OFF_GPIO_CLR 32'he002c10c
`define PFS_OFF_GPIO_PIN 32'he002c110
`define PFS_OFF_P1_DIR 32'he002c120
`define PFS_OFF_P1_OUT 32'he002c124
`define PFS_OFF_P1_PIN 32'he002c128
`define PFS_SEL_HIGH_RST 32'h15400000
`define PFS_SEL_HIGH_MASK 32'h3fcfffff
`define PFS_SEL_P1_MASK 32'h0000000c
`define PFS_DEBUG_BIT 2
`define PFS_TRACE_BIT 3
`define PFS_DEBUG_LINES 32'hfc000000
`define PFS_TRACE_LINES 32'h03ff0000
`define PFS_ZERO32 32'h00000000
`endif

// [hw/pfs_pkg.sv]
// Types shared by the pin function select block.
package pfs_pkg;
    typedef enum logic [1:0] {
        PFS_FN_GPIO,
        PFS_FN_ALT1,
        PFS_FN_ALT2,
        PFS_FN_ALT3
    } pfs_fn_e;
    typedef logic [31:0] pfs_word_t;
endpackage

// [hw/pfs_pin_mux.sv]
// Pin function select and GPIO for port 0 lines 16 to 31 and port 1 debug/trace groups.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "pfs_defines.svh"

// =====================================================================
// Notes on behaviour
// (R1) GPIO direction bit acts only while the pin's field selects GPIO.
// (R2) Non-GPIO functions set pin direction from the peripheral automatically.
// (R3) Software must not write reserved encodings, including all of lines 26 and 31.
// (R4) Line 16: GPIO, irq line 0, timer0 match 2, timer0 capture 2; reset 00.
// (R5) Lines 17 and 19 route to GPIO, timer1 capture/match 2, SPI1 clock or MOSI.
// (R6) Line 18: timer1 capture3, SPI1 MISO, match3; line 21: PULSE_OUTPUT_5, capture3.
// (R7) Line 22: capture0, match0; line 30: analog 3, irq line 3, capture0.
// (R8) Line 23: GPIO or CAN2 receive; other codes reserved; reset 00.
// (R9) Line 24: GPIO or CAN2 transmit; other codes reserved; reset 00.
// (R10) Line 25: GPIO or CAN1 receive; other codes reserved; reset 00.
// (R11) Lines 27, 28: GPIO, analog 0/1, timer0 capture, timer0 match; reset 01.
// (R12) Line 29: GPIO, analog 2, capture3, match3; lines 29 and 30 reset 01.
// (R13) Select bit 2 gives port1 lines 31..26 to the debug port; reset 0.
// (R14) Select bit 3 gives port1 lines 25..16 to the trace port; reset 0.
// (R15) Unrouted pins are driven and sampled under GPIO register control.
// (R16) Each GPIO pin has its own direction bit, changeable any time.
// (R17) Set and clear registers change any output bits in one write.
// (R18) Reads return both the output register and the live pin levels.
// (R19) After reset every GPIO direction bit is cleared, so pins are inputs.
// (R20) Reserved select bits ignore writes and read back as zero.
module pfs_pin_mux
    import pfs_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // Register port.
    input wire logic [31:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // Port 0 pads, lines 31..16 in bits 15..0.
    input wire logic [15:0] p0_pin_i,
    output logic [15:0] p0_pin_o,
    output logic [15:0] p0_pin_oe_o,
    // Port 0 peripheral side: output value and output enable from each peripheral.
    input wire logic [15:0] p0_periph_out_i,
    input wire logic [15:0] p0_periph_oe_i,
    output logic [15:0] p0_periph_in_o,
    output logic [15:0] p0_alt_sel_o,
    output logic [31:0] p0_fn_sel_o,
    // Port 1 pads, lines 31..16 in bits 15..0.
    input wire logic [15:0] p1_pin_i,
    output logic [15:0] p1_pin_o,
    output logic [15:0] p1_pin_oe_o,
    // Port 1 debug and trace side.
    input wire logic [15:0] p1_dbg_out_i,
    input wire logic [15:0] p1_dbg_oe_i,
    output logic [15:0] p1_dbg_in_o,
    output logic debug_en_o,
    output logic trace_en_o
);

    // =================================================================
    // Registers
    pfs_word_t sel_high;
    pfs_word_t sel_p1;
    logic [15:0] gpio_direction_reg;
    logic [15:0] gpio_out;
    logic [15:0] p1_dir;
    logic [15:0] p1_out;

    logic [15:0] p0_alt;
    logic [15:0] p1_alt;
    pfs_word_t p1_group;
    logic [15:0] next_p0_pin;
    logic [15:0] next_p0_oe;
    logic [15:0] next_p1_pin;
    logic [15:0] next_p1_oe;
    pfs_word_t next_rdata;

    // (R4) select reset values
    // (R20) reserved bits masked
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            sel_high <= `PFS_SEL_HIGH_RST;
        end else if (wr_i && addr_i == `PFS_OFF_SEL_HIGH) begin
            sel_high <= wdata_i & `PFS_SEL_HIGH_MASK;
        end
    end

    // (R13) debug trace select
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            sel_p1 <= `PFS_ZERO32;
        end else if (wr_i && addr_i == `PFS_OFF_SEL_P1) begin
            sel_p1 <= wdata_i & `PFS_SEL_P1_MASK;
        end
    end

    // (R19) directions reset input
    // (R16) per-bit direction
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            gpio_direction_reg <= 16'h0000;
            p1_dir <= 16'h0000;
        end else if (wr_i && addr_i == `PFS_OFF_GPIO_DIR) begin
            gpio_direction_reg <= wdata_i[31:16];
        end else if (wr_i && addr_i == `PFS_OFF_P1_DIR) begin
            p1_dir <= wdata_i[31:16];
        end
    end

    // (R17) set clear outputs
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            gpio_out <= 16'h0000;
            p1_out <= 16'h0000;
        end else if (wr_i && addr_i == `PFS_OFF_GPIO_OUT) begin
            gpio_out <= wdata_i[31:16];
        end else if (wr_i && addr_i == `PFS_OFF_GPIO_SET) begin
            gpio_out <= gpio_out | wdata_i[31:16];
        end else if (wr_i && addr_i == `PFS_OFF_GPIO_CLR) begin
            gpio_out <= gpio_out & ~wdata_i[31:16];
        end else if (wr_i && addr_i == `PFS_OFF_P1_OUT) begin
            p1_out <= wdata_i[31:16];
        end
    end

    // =================================================================
    // Routing
    // (R5) field per line
    // (R6) field per line
    // (R7) field per line
    // (R8) CAN2 receive
    // (R9) CAN2 transmit
    // (R10) CAN1 receive
    // (R11) analog timer fields
    // (R12) analog timer fields
    // (R3) reserved codes unsupported
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            p0_alt[i] = pfs_fn_e'(sel_high[2*i +: 2]) != PFS_FN_GPIO;
        end
        // (R13) (R14) debug and trace groups
        p1_group = `PFS_ZERO32;
        if (sel_p1[`PFS_DEBUG_BIT]) begin
            p1_group = p1_group | `PFS_DEBUG_LINES;
        end
        if (sel_p1[`PFS_TRACE_BIT]) begin
            p1_group = p1_group | `PFS_TRACE_LINES;
        end
        p1_alt = p1_group[31:16];
    end

    // (R1) direction gated GPIO
    // (R2) peripheral sets direction
    // (R15) GPIO drives unrouted
    always_comb begin
        next_p0_pin = (p0_alt & p0_periph_out_i) | (~p0_alt & gpio_out);
        next_p0_oe = (p0_alt & p0_periph_oe_i) | (~p0_alt & gpio_direction_reg);
        next_p1_pin = (p1_alt & p1_dbg_out_i) | (~p1_alt & p1_out);
        next_p1_oe = (p1_alt & p1_dbg_oe_i) | (~p1_alt & p1_dir);
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            p0_pin_o <= 16'h0000;
            p0_pin_oe_o <= 16'h0000;
            p1_pin_o <= 16'h0000;
            p1_pin_oe_o <= 16'h0000;
        end else begin
            p0_pin_o <= next_p0_pin;
            p0_pin_oe_o <= next_p0_oe;
            p1_pin_o <= next_p1_pin;
            p1_pin_oe_o <= next_p1_oe;
        end
    end

    // Peripheral-side inputs see the pad only when routed to them.
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            p0_periph_in_o <= 16'h0000;
            p1_dbg_in_o <= 16'h0000;
            p0_alt_sel_o <= 16'h0000;
            p0_fn_sel_o <= `PFS_SEL_HIGH_RST;
            debug_en_o <= 1'b0;
            trace_en_o <= 1'b0;
        end else begin
            p0_periph_in_o <= p0_pin_i & p0_alt;
            p1_dbg_in_o <= p1_pin_i & p1_alt;
            p0_alt_sel_o <= p0_alt;
            p0_fn_sel_o <= sel_high;
            debug_en_o <= sel_p1[`PFS_DEBUG_BIT];
            trace_en_o <= sel_p1[`PFS_TRACE_BIT];
        end
    end

    // =================================================================
    // Read path
    // (R18) output and pin
    always_comb begin
        next_rdata = `PFS_ZERO32;
        if (addr_i == `PFS_OFF_SEL_HIGH) begin
            next_rdata = sel_high;
        end else if (addr_i == `PFS_OFF_SEL_P1) begin
            next_rdata = sel_p1;
        end else if (addr_i == `PFS_OFF_GPIO_DIR) begin
            next_rdata = {gpio_direction_reg, 16'h0000};
        end else if (addr_i == `PFS_OFF_GPIO_OUT) begin
            next_rdata = {gpio_out, 16'h0000};
        end else if (addr_i == `PFS_OFF_GPIO_PIN) begin
            next_rdata = {p0_pin_i, 16'h0000};
        end else if (addr_i == `PFS_OFF_P1_DIR) begin
            next_rdata = {p1_dir, 16'h0000};
        end else if (addr_i == `PFS_OFF_P1_OUT) begin
            next_rdata = {p1_out, 16'h0000};
        end else if (addr_i == `PFS_OFF_P1_PIN) begin
            next_rdata = {p1_pin_i, 16'h0000};
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            rdata_o <= `PFS_ZERO32;
        end else if (rd_i) begin
            rdata_o <= next_rdata;
        end else begin
            rdata_o <= `PFS_ZERO32;
        end
    end

    // =================================================================
    // Assertions
    property p_gpio_oe;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (sel_high[1:0] == 2'b00) |=> (p0_pin_oe_o[0] == $past(gpio_direction_reg[0]));
    endproperty
    a_gpio_oe: assert property (p_gpio_oe) else $error("gpio oe mismatch"); // (R1)

    property p_alt_oe;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (sel_high[3:2] != 2'b00) |=> (p0_pin_oe_o[1] == $past(p0_periph_oe_i[1]));
    endproperty
    a_alt_oe: assert property (p_alt_oe) else $error("peripheral oe mismatch"); // (R2)

    property p_sel_reset;
        @(posedge ref_clk_i) $rose(resetn_i) |-> sel_high == `PFS_SEL_HIGH_RST;
    endproperty
    a_sel_reset: assert property (p_sel_reset) else $error("select reset wrong"); // (R11)

    property p_dir_reset;
        @(posedge ref_clk_i) $rose(resetn_i) |-> gpio_direction_reg == 16'h0000;
    endproperty
    a_dir_reset: assert property (p_dir_reset) else $error("direction reset wrong"); // (R19)

    property p_set;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (wr_i && addr_i == `PFS_OFF_GPIO_SET)
            |=> ((gpio_out & $past(wdata_i[31:16])) == $past(wdata_i[31:16]));
    endproperty
    a_set: assert property (p_set) else $error("set write failed"); // (R17)

    property p_clr;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (wr_i && addr_i == `PFS_OFF_GPIO_CLR) |=> ((gpio_out & $past(wdata_i[31:16])) == 16'h0000);
    endproperty
    a_clr: assert property (p_clr) else $error("clear write failed"); // (R17)

    property p_reserved;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        ((sel_high & ~`PFS_SEL_HIGH_MASK) == `PFS_ZERO32)
            && ((sel_p1 & ~`PFS_SEL_P1_MASK) == `PFS_ZERO32);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits set"); // (R20)

    property p_debug;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        sel_p1[`PFS_DEBUG_BIT] |=> (p1_pin_oe_o[15:10] == $past(p1_dbg_oe_i[15:10]));
    endproperty
    a_debug: assert property (p_debug) else $error("debug group not routed"); // (R13)

    property p_trace;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        !sel_p1[`PFS_TRACE_BIT] |=> (p1_pin_oe_o[9:0] == $past(p1_dir[9:0]));
    endproperty
    a_trace: assert property (p_trace) else $error("trace group not gpio"); // (R14)

    property p_pin_read;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (rd_i && addr_i == `PFS_OFF_GPIO_PIN) |=> (rdata_o[31:16] == $past(p0_pin_i));
    endproperty
    a_pin_read: assert property (p_pin_read) else $error("pin read wrong"); // (R18)

    property p_dir_write;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (wr_i && addr_i == `PFS_OFF_GPIO_DIR)
            |=> (gpio_direction_reg == $past(wdata_i[31:16]));
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("direction write failed"); // (R16)

    property p_out_read;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (rd_i && addr_i == `PFS_OFF_GPIO_OUT) |=> (rdata_o[31:16] == $past(gpio_out));
    endproperty
    a_out_read: assert property (p_out_read) else $error("output register read wrong"); // (R18)

    // Read data stand for one cycle after each cycle with rd_i high, then fall back to zero.
    property p_rdata_idle;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        !rd_i |=> (rdata_o == `PFS_ZERO32);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared"); // (R18)

    property p_gpio_drive;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (sel_high[1:0] == 2'b00) |=> (p0_pin_o[0] == $past(gpio_out[0]));
    endproperty
    a_gpio_drive: assert property (p_gpio_drive) else $error("gpio drive mismatch"); // (R15)

    property p_periph_gate;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        1'b1 |=> ((p0_periph_in_o & ~$past(p0_alt)) == 16'h0000);
    endproperty
    a_periph_gate: assert property (p_periph_gate) else $error("gpio line leaks"); // (R15)

    property p_can2_rx;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (sel_high[15:14] == 2'b01) |=> (p0_periph_in_o[7] == $past(p0_pin_i[7]));
    endproperty
    a_can2_rx: assert property (p_can2_rx) else $error("can2 receive not routed"); // (R8)

    property p_can2_tx;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (sel_high[17:16] == 2'b01) |=> (p0_pin_o[8] == $past(p0_periph_out_i[8]));
    endproperty
    a_can2_tx: assert property (p_can2_tx) else $error("can2 transmit not routed"); // (R9)

    property p_can1_rx;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (sel_high[19:18] == 2'b01) |=> (p0_periph_in_o[9] == $past(p0_pin_i[9]));
    endproperty
    a_can1_rx: assert property (p_can1_rx) else $error("can1 receive not routed"); // (R10)

    property p_trace_on;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        sel_p1[`PFS_TRACE_BIT] |=> (p1_pin_oe_o[9:0] == $past(p1_dbg_oe_i[9:0]));
    endproperty
    a_trace_on: assert property (p_trace_on) else $error("trace group not routed"); // (R14)

    property p_p1_reset;
        @(posedge ref_clk_i) $rose(resetn_i) |-> (p1_dir == 16'h0000) && (sel_p1 == `PFS_ZERO32);
    endproperty
    a_p1_reset: assert property (p_p1_reset) else $error("port1 reset wrong"); // (R19)

endmodule
`default_nettype wire

// [verif/pfs_pad_model.sv]
// Pad model: driven lines read back their drive, released lines toggle.
`timescale 1ns/1ps
`default_nettype none
module pfs_pad_model (
    // Clock.
    input wire logic ref_clk_i,
    // Pad drive from the block.
    input wire logic [15:0] p0_o_i,
    input wire logic [15:0] p0_oe_i,
    input wire logic [15:0] p1_o_i,
    input wire logic [15:0] p1_oe_i,
    // Pad levels to the block.
    output logic [15:0] p0_i_o,
    output logic [15:0] p1_i_o
);
    logic [15:0] float_q = 16'h5a5a;
    // Released lines change every cycle so a stale level never matches.
    always @(posedge ref_clk_i) begin
        float_q <= ~float_q;
    end
    assign p0_i_o = (p0_oe_i & p0_o_i) | (~p0_oe_i & float_q);
    assign p1_i_o = (p1_oe_i & p1_o_i) | (~p1_oe_i & float_q);
endmodule
`default_nettype wire

// [verif/port0_pin_function_select_tb.sv]
// Self-checking testbench of the pin function select block.
`timescale 1ns/1ps
`default_nettype none
`include "pfs_defines.svh"
module port0_pin_function_select_tb;
    import pfs_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic den, ten;
    pfs_word_t addr = '0;
    pfs_word_t wdata = '0;
    pfs_word_t rdata, fsel, sel, dir, out, p1s, p1d, p1o, r;
    logic [15:0] pout = '0;
    logic [15:0] poe = '0;
    logic [15:0] dout = '0;
    logic [15:0] doe = '0;
    logic [15:0] p0i, p0o, p0oe, pin0, alt, p1i, p1o_pad, p1oe, din;
    int fails = 0;
    int check_count = 0;
    pfs_pin_mux dut (.ref_clk_i(ref_clk), .resetn_i(resetn), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .p0_pin_i(p0i),
        .p0_pin_o(p0o), .p0_pin_oe_o(p0oe), .p0_periph_out_i(pout),
        .p0_periph_oe_i(poe), .p0_periph_in_o(pin0), .p0_alt_sel_o(alt),
        .p0_fn_sel_o(fsel), .p1_pin_i(p1i), .p1_pin_o(p1o_pad), .p1_pin_oe_o(p1oe),
        .p1_dbg_out_i(dout), .p1_dbg_oe_i(doe), .p1_dbg_in_o(din),
        .debug_en_o(den), .trace_en_o(ten));
    pfs_pad_model pads (.ref_clk_i(ref_clk), .p0_o_i(p0o), .p0_oe_i(p0oe),
        .p1_o_i(p1o_pad), .p1_oe_i(p1oe), .p0_i_o(p0i), .p1_i_o(p1i));
    // ==============================================================
    // Bus tasks and expectations.
    task automatic cmp(input string nm, input pfs_word_t exp, input pfs_word_t got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr_reg(input pfs_word_t a, input pfs_word_t d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input pfs_word_t a, input pfs_word_t exp, input string nm);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        cmp(nm, exp, rdata);
    endtask
    function automatic pfs_word_t legal(input pfs_word_t v);
        v[15] = 1'b0;
        v[17] = 1'b0;
        v[19] = 1'b0;
        v[21:20] = 2'b00;
        v[31:30] = 2'b00;
        if (v[11:10] == 2'b10) v[10] = 1'b1;
        if (v[13:12] == 2'b01) v[13] = 1'b1;
        return v;
    endfunction
    function automatic logic [47:0] exp_p0(input pfs_word_t s);
        logic [15:0] a, e, v;
        for (int k = 0; k < 16; k++) begin
            a[k] = (s[2*k +: 2] != 2'b00) && k != 10 && k != 15;
            e[k] = a[k] ? poe[k] : dir[16+k];
            v[k] = a[k] ? pout[k] : out[16+k];
        end
        return {a, e, v};
    endfunction
    function automatic pfs_word_t exp_p1();
        logic [15:0] m;
        m = {{6{p1s[2]}}, {10{p1s[3]}}};
        return {(m & doe) | (~m & p1d[31:16]), (m & dout) | (~m & p1o[31:16])};
    endfunction
    task automatic chk();
        logic [47:0] e0;
        logic [15:0] m;
        logic [15:0] m1;
        repeat (3) @(posedge ref_clk);
        #1;
        e0 = exp_p0(sel);
        m = e0[47:32] & poe;
        m1 = {{6{p1s[`PFS_DEBUG_BIT]}}, {10{p1s[`PFS_TRACE_BIT]}}};
        cmp("p0_alt_oe", e0[47:16], {alt, p0oe});
        cmp("p0_out_in", {e0[15:0], m & pout}, {p0o, pin0 & (m | ~e0[47:32])});
        cmp("p1_oe_out", exp_p1(), {p1oe, p1o_pad});
        cmp("p1_dbg_in", {16'h0, m1 & doe & dout}, {16'h0, din & (~m1 | doe)});
        cmp("dbg_trace", {30'h0, p1s[2], p1s[3]}, {30'h0, den, ten});
        cmp("fn_sel", sel, fsel);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ==============================================================
    // Clock, watchdog and test sequence.
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        close_out();
    end
    initial begin
        void'($urandom(32'hea2edaa8));
        sel = `PFS_SEL_HIGH_RST;
        {dir, out, p1s, p1d, p1o} = '0;
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        rd_reg(`PFS_OFF_SEL_HIGH, `PFS_SEL_HIGH_RST, "sel_high");
        rd_reg(`PFS_OFF_SEL_P1, '0, "sel_p1");
        rd_reg(`PFS_OFF_GPIO_DIR, '0, "gpio_dir");
        rd_reg(32'he002c200, '0, "unmapped");
        chk();
        $display("reset test done");
        for (int e = 0; e < 4; e++) begin
            sel = legal({16{e[1:0]}}) & `PFS_SEL_HIGH_MASK;
            wr_reg(`PFS_OFF_SEL_HIGH, legal({16{e[1:0]}}));
            chk();
            rd_reg(`PFS_OFF_SEL_HIGH, sel, "sel_sweep");
        end
        $display("encoding test done");
        for (int i = 0; i < 24; i++) begin
            r = legal($urandom());
            sel = r & `PFS_SEL_HIGH_MASK;
            wr_reg(`PFS_OFF_SEL_HIGH, r);
            r = $urandom();
            p1s = r & `PFS_SEL_P1_MASK;
            wr_reg(`PFS_OFF_SEL_P1, r);
            r = $urandom();
            dir = r & 32'hffff0000;
            wr_reg(`PFS_OFF_GPIO_DIR, r);
            r = $urandom();
            out = r & 32'hffff0000;
            wr_reg(`PFS_OFF_GPIO_OUT, r);
            r = $urandom();
            p1d = r & 32'hffff0000;
            wr_reg(`PFS_OFF_P1_DIR, r);
            r = $urandom();
            p1o = r & 32'hffff0000;
            wr_reg(`PFS_OFF_P1_OUT, r);
            r = $urandom();
            pout <= r[15:0];
            poe <= r[31:16];
            r = $urandom();
            dout <= r[15:0];
            doe <= r[31:16];
            chk();
            rd_reg(`PFS_OFF_SEL_HIGH, sel, "sel_high");
            rd_reg(`PFS_OFF_SEL_P1, p1s, "sel_p1");
            rd_reg(`PFS_OFF_GPIO_DIR, dir, "gpio_dir");
            rd_reg(`PFS_OFF_P1_OUT, p1o, "p1_out");
        end
        $display("random test done");
        sel = '0;
        dir = 32'hffff0000;
        out = 32'h80040000;
        p1s = '0;
        p1d = 32'hffff0000;
        wr_reg(`PFS_OFF_SEL_HIGH, sel);
        wr_reg(`PFS_OFF_SEL_P1, p1s);
        wr_reg(`PFS_OFF_GPIO_DIR, dir);
        wr_reg(`PFS_OFF_P1_DIR, p1d);
        wr_reg(`PFS_OFF_GPIO_OUT, '0);
        wr_reg(`PFS_OFF_GPIO_SET, 32'h00050000);
        wr_reg(`PFS_OFF_GPIO_CLR, 32'h00010000);
        wr_reg(`PFS_OFF_GPIO_SET, 32'h80000000);
        rd_reg(`PFS_OFF_GPIO_OUT, out, "gpio_out");
        chk();
        rd_reg(`PFS_OFF_GPIO_PIN, out, "gpio_pin");
        rd_reg(`PFS_OFF_P1_PIN, p1o, "p1_pin");
        $display("set clear test done");
        @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        sel = `PFS_SEL_HIGH_RST;
        {dir, out, p1s, p1d, p1o} = '0;
        rd_reg(`PFS_OFF_GPIO_OUT, '0, "out_rst");
        rd_reg(`PFS_OFF_SEL_HIGH, sel, "sel_rst");
        chk();
        $display("mid-run reset test done");
        close_out();
    end
endmodule
`default_nettype wire
